/* camhp_pkg.sv */
package camhp_pkg;
  // Timing of the host-driven strobe cycle
  localparam int CLK_NS = 10;
  localparam int SETUP_NS = 10;
  localparam int STROBE_LOW_NS = 50;
  localparam int STROBE_HIGH_NS = 20;
  localparam int INIT_NS = 100;
  localparam int SETUP_CYC = (SETUP_NS + CLK_NS - 1) / CLK_NS;
  localparam int STROBE_LOW_CYC = (STROBE_LOW_NS + CLK_NS - 1) / CLK_NS;
  localparam int STROBE_HIGH_CYC = (STROBE_HIGH_NS + CLK_NS - 1) / CLK_NS;
  localparam int INIT_CYC = (INIT_NS + CLK_NS - 1) / CLK_NS;
  localparam int CNT_W = 8;

  // Register map, byte addresses
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_WDATA = 8'h04;
  localparam logic [7:0] REG_RDATA = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0C;

  // Control register fields
  localparam int CTRL_START = 0;
  localparam int CTRL_READ = 1;
  localparam int CTRL_DATA = 2;
  localparam int CTRL_CHAIN = 3;
  localparam int CTRL_INIT = 4;

  // Status register fields
  localparam int ST_BUSY = 0;
  localparam int ST_DONE = 1;
  localparam int ST_OWN_HIT = 2;
  localparam int ST_OWN_MULTI = 3;
  localparam int ST_SYS_MATCH = 4;
  localparam int ST_SYS_FULL = 5;

  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef struct packed {
    logic awvalid;
    logic [7:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [7:0] araddr;
    logic rready;
  } camhp_axi_req_type;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } camhp_axi_resp_type;

  // Pins the host drives toward the first device of the chain
  typedef struct packed {
    logic chip_strobe_n;
    logic direction_sel_n;
    logic command_or_data_n;
    logic chain_enable_n;
    logic init_clear_n;
    logic cascade_match_in_n;
    logic cascade_full_in_n;
    logic [15:0] io_bus_out;
    logic io_bus_oe_n;
  } camhp_pins_type;

  // Flags sampled from the chain
  typedef struct packed {
    logic own_hit_n;
    logic own_multi_hit_n;
    logic cascade_match_out_n;
    logic cascade_full_out_n;
  } camhp_flags_type;

  typedef enum logic [2:0] {
    CAMHP_IDLE,
    CAMHP_INIT,
    CAMHP_SETUP,
    CAMHP_LOW,
    CAMHP_HIGH
  } camhp_state_type;
endpackage : camhp_pkg

/* camhp_host.sv */
// Local design decisions: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/100ps
module camhp_host #(
  parameter int STROBE_LOW = camhp_pkg::STROBE_LOW_CYC,
  parameter int INIT_LEN = camhp_pkg::INIT_CYC
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire camhp_pkg::camhp_axi_req_type axi_req,
  output camhp_pkg::camhp_axi_resp_type axi_resp,
  output camhp_pkg::camhp_pins_type pins,
  input wire logic [15:0] io_bus_in,
  input wire camhp_pkg::camhp_flags_type flags
);
  camhp_pkg::camhp_state_type state, next_state;
  logic [camhp_pkg::CNT_W-1:0] count, next_count;
  logic cyc_read, next_cyc_read;
  logic cyc_data, next_cyc_data;
  logic cyc_chain, next_cyc_chain;
  logic [15:0] wdata, next_wdata;
  logic [15:0] rdata, next_rdata;
  logic done, next_done;
  camhp_pkg::camhp_flags_type flag_q, next_flag_q;
  logic bvalid, next_bvalid;
  logic [1:0] bresp, next_bresp;
  logic rvalid, next_rvalid;
  logic [31:0] rd_word, next_rd_word;
  logic [1:0] rresp, next_rresp;
  logic wr_take;
  logic rd_take;
  logic busy;

  assign busy = (state != camhp_pkg::CAMHP_IDLE);
  // Address and data taken together; keeps the slave free of half-writes
  assign wr_take = axi_req.awvalid && axi_req.wvalid && !bvalid;
  assign rd_take = axi_req.arvalid && !rvalid;

  always_comb begin
    next_state = state;
    next_count = count;
    next_cyc_read = cyc_read;
    next_cyc_data = cyc_data;
    next_cyc_chain = cyc_chain;
    next_wdata = wdata;
    next_rdata = rdata;
    next_done = done;
    next_flag_q = flag_q;
    next_bvalid = bvalid && !axi_req.bready;
    next_bresp = bresp;
    next_rvalid = rvalid && !axi_req.rready;
    next_rd_word = rd_word;
    next_rresp = rresp;
    if (wr_take) begin
      next_bvalid = 1'b1;
      next_bresp = camhp_pkg::RESP_OKAY;
      unique case (axi_req.awaddr)
        camhp_pkg::REG_CTRL: begin
          // Orders arriving while a cycle runs are dropped
          if (!busy && axi_req.wstrb[0]) begin
            if (axi_req.wdata[camhp_pkg::CTRL_INIT]) begin
              next_state = camhp_pkg::CAMHP_INIT;
              next_count = camhp_pkg::CNT_W'(INIT_LEN - 1);
              next_done = 1'b0;
            end else if (axi_req.wdata[camhp_pkg::CTRL_START]) begin
              next_cyc_read = axi_req.wdata[camhp_pkg::CTRL_READ];
              next_cyc_data = axi_req.wdata[camhp_pkg::CTRL_DATA];
              next_cyc_chain = axi_req.wdata[camhp_pkg::CTRL_CHAIN];
              next_state = camhp_pkg::CAMHP_SETUP;
              next_count = camhp_pkg::CNT_W'(camhp_pkg::SETUP_CYC - 1);
              next_done = 1'b0;
            end
          end
        end
        camhp_pkg::REG_WDATA: begin
          if (axi_req.wstrb[0]) next_wdata[7:0] = axi_req.wdata[7:0];
          if (axi_req.wstrb[1]) next_wdata[15:8] = axi_req.wdata[15:8];
        end
        camhp_pkg::REG_RDATA, camhp_pkg::REG_STATUS: ;
        default: next_bresp = camhp_pkg::RESP_SLVERR;
      endcase
    end
    if (rd_take) begin
      next_rvalid = 1'b1;
      next_rresp = camhp_pkg::RESP_OKAY;
      next_rd_word = 32'h0000_0000;
      unique case (axi_req.araddr)
        camhp_pkg::REG_CTRL: ;
        camhp_pkg::REG_WDATA: next_rd_word[15:0] = wdata;
        camhp_pkg::REG_RDATA: next_rd_word[15:0] = rdata;
        camhp_pkg::REG_STATUS: begin
          next_rd_word[camhp_pkg::ST_BUSY] = busy;
          next_rd_word[camhp_pkg::ST_DONE] = done;
          next_rd_word[camhp_pkg::ST_OWN_HIT] = !flag_q.own_hit_n;
          next_rd_word[camhp_pkg::ST_OWN_MULTI] = !flag_q.own_multi_hit_n;
          next_rd_word[camhp_pkg::ST_SYS_MATCH] = !flag_q.cascade_match_out_n;
          next_rd_word[camhp_pkg::ST_SYS_FULL] = !flag_q.cascade_full_out_n;
        end
        default: next_rresp = camhp_pkg::RESP_SLVERR;
      endcase
    end
    unique case (state)
      camhp_pkg::CAMHP_IDLE: ;
      camhp_pkg::CAMHP_INIT: begin
        if (count == '0) begin
          next_state = camhp_pkg::CAMHP_HIGH;
          next_count = camhp_pkg::CNT_W'(camhp_pkg::STROBE_HIGH_CYC - 1);
        end else next_count = count - 1'b1;
      end
      camhp_pkg::CAMHP_SETUP: begin
        if (count == '0) begin
          next_state = camhp_pkg::CAMHP_LOW;
          next_count = camhp_pkg::CNT_W'(STROBE_LOW - 1);
        end else next_count = count - 1'b1;
      end
      camhp_pkg::CAMHP_LOW: begin
        if (count == '0) begin
          // Sample read data on the last low cycle, before the bus floats
          if (cyc_read) next_rdata = io_bus_in;
          next_state = camhp_pkg::CAMHP_HIGH;
          next_count = camhp_pkg::CNT_W'(camhp_pkg::STROBE_HIGH_CYC - 1);
        end else next_count = count - 1'b1;
      end
      camhp_pkg::CAMHP_HIGH: begin
        if (count == '0) begin
          // Flags settle once the strobe has risen
          next_flag_q = flags;
          next_done = 1'b1;
          next_state = camhp_pkg::CAMHP_IDLE;
        end else next_count = count - 1'b1;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      state <= camhp_pkg::CAMHP_IDLE;
      count <= '0;
      cyc_read <= 1'b1;
      cyc_data <= 1'b1;
      cyc_chain <= 1'b0;
      wdata <= 16'h0000;
      rdata <= 16'h0000;
      done <= 1'b0;
      flag_q <= '1;
      bvalid <= 1'b0;
      bresp <= camhp_pkg::RESP_OKAY;
      rvalid <= 1'b0;
      rd_word <= 32'h0000_0000;
      rresp <= camhp_pkg::RESP_OKAY;
    end else begin
      state <= next_state;
      count <= next_count;
      cyc_read <= next_cyc_read;
      cyc_data <= next_cyc_data;
      cyc_chain <= next_cyc_chain;
      wdata <= next_wdata;
      rdata <= next_rdata;
      done <= next_done;
      flag_q <= next_flag_q;
      bvalid <= next_bvalid;
      bresp <= next_bresp;
      rvalid <= next_rvalid;
      rd_word <= next_rd_word;
      rresp <= next_rresp;
    end
  end

  always_comb begin
    axi_resp.awready = wr_take;
    axi_resp.wready = wr_take;
    axi_resp.bvalid = bvalid;
    axi_resp.bresp = bresp;
    axi_resp.arready = rd_take;
    axi_resp.rvalid = rvalid;
    axi_resp.rdata = rd_word;
    axi_resp.rresp = rresp;
    pins.chip_strobe_n = (state != camhp_pkg::CAMHP_LOW);
    pins.direction_sel_n = cyc_read;
    pins.command_or_data_n = cyc_data;
    // Chain stays off outside cycles and through the init pulse
    pins.chain_enable_n = !(cyc_chain && (state == camhp_pkg::CAMHP_SETUP
                            || state == camhp_pkg::CAMHP_LOW));
    pins.init_clear_n = (state != camhp_pkg::CAMHP_INIT);
    pins.cascade_match_in_n = 1'b1;
    pins.cascade_full_in_n = 1'b0;
    pins.io_bus_out = wdata;
    pins.io_bus_oe_n = !(!cyc_read && (state == camhp_pkg::CAMHP_SETUP
                         || state == camhp_pkg::CAMHP_LOW));
  end

  // Strobe-low cycle count, so the width check follows STROBE_LOW instead of a fixed repeat
  logic [camhp_pkg::CNT_W-1:0] low_len, next_low_len;
  localparam int DONE_LAG = camhp_pkg::STROBE_HIGH_CYC;

  always_comb begin
    next_low_len = pins.chip_strobe_n ? '0 : low_len + 1'b1;
  end

  always_ff @(posedge clock) begin
    if (!rst_n) low_len <= '0;
    else low_len <= next_low_len;
  end

  property p_read_no_drive;
    @(posedge clock) disable iff (!rst_n) pins.direction_sel_n |-> pins.io_bus_oe_n;
  endproperty
  a_read_no_drive: assert property (p_read_no_drive) else $error("Host drove bus in read");

  property p_init_chain_off;
    @(posedge clock) disable iff (!rst_n) !pins.init_clear_n |-> pins.chain_enable_n;
  endproperty
  a_init_chain_off: assert property (p_init_chain_off) else $error("Chain on during init");

  property p_init_strobe_high;
    @(posedge clock) disable iff (!rst_n)
      !pins.init_clear_n |-> pins.chip_strobe_n;
  endproperty
  a_init_strobe_high: assert property (p_init_strobe_high) else $error("Strobe low in init");

  property p_strobe_width;
    @(posedge clock) disable iff (!rst_n)
      $rose(pins.chip_strobe_n) |-> low_len == camhp_pkg::CNT_W'(STROBE_LOW);
  endproperty
  a_strobe_width: assert property (p_strobe_width) else $error("Strobe low width wrong");

  property p_ctrl_stable;
    @(posedge clock) disable iff (!rst_n)
      !pins.chip_strobe_n |-> $stable(pins.direction_sel_n) && $stable(pins.command_or_data_n)
                               && $stable(pins.chain_enable_n);
  endproperty
  a_ctrl_stable: assert property (p_ctrl_stable) else $error("Controls moved in cycle");

  property p_cmd_sel;
    @(posedge clock) disable iff (!rst_n)
      $fell(pins.chip_strobe_n) |-> $stable(pins.command_or_data_n)
        && $stable(pins.direction_sel_n);
  endproperty
  a_cmd_sel: assert property (p_cmd_sel) else $error("Command select mismatch");

  property p_write_drives;
    @(posedge clock) disable iff (!rst_n)
      (!pins.chip_strobe_n && !pins.direction_sel_n) |-> !pins.io_bus_oe_n;
  endproperty
  a_write_drives: assert property (p_write_drives) else $error("Write data not driven");

  property p_flag_capture;
    @(posedge clock) disable iff (!rst_n)
      $rose(pins.chip_strobe_n) && pins.init_clear_n |-> ##DONE_LAG done;
  endproperty
  a_flag_capture: assert property (p_flag_capture) else $error("Flags not captured");

  property p_chain_ties;
    @(posedge clock) disable iff (!rst_n) pins.cascade_match_in_n && !pins.cascade_full_in_n;
  endproperty
  a_chain_ties: assert property (p_chain_ties) else $error("Chain head not tied");

  c_write: cover property (@(posedge clock) disable iff (!rst_n)
    $fell(pins.chip_strobe_n) && !pins.direction_sel_n);
  c_read: cover property (@(posedge clock) disable iff (!rst_n)
    $fell(pins.chip_strobe_n) && pins.direction_sel_n);
  c_chain: cover property (@(posedge clock) disable iff (!rst_n)
    $fell(pins.chip_strobe_n) && !pins.chain_enable_n);
  c_init: cover property (@(posedge clock) disable iff (!rst_n) $rose(pins.init_clear_n));
endmodule : camhp_host

/* camhp_dev_model.sv */
`timescale 1ns/100ps
module camhp_dev_model (
  input wire camhp_pkg::camhp_pins_type pins,
  output logic [15:0] io_bus_in,
  output camhp_pkg::camhp_flags_type flags
);
  // Key 1234 stored twice so the multiple-hit path is reachable
  localparam logic [15:0] KEYS [4] = '{16'h1234, 16'h1234, 16'h00aa, 16'h5a5a};
  logic wr_n, cmd_n, chain_n;
  logic [15:0] ctrl, cmpd, last;
  int hits, cycles;
  // No pull-ups: a released bus shows the inverse of its last value, never a stale copy
  assign io_bus_in = !pins.io_bus_oe_n ? pins.io_bus_out :
    (!pins.chip_strobe_n && wr_n) ? (cmd_n ? cmpd : ctrl) : ~last;
  task automatic clear;
    {wr_n, cmd_n, chain_n} = 3'b111;
    {ctrl, cmpd, last} = 48'h0000_0000_0000;
    hits = 0;
    cycles = 0;
    flags = 4'b1111;
  endtask : clear
  initial clear();
  always @(negedge pins.init_clear_n) clear();
  always @(negedge pins.chip_strobe_n) begin
    wr_n = pins.direction_sel_n;
    cmd_n = pins.command_or_data_n;
    chain_n = pins.chain_enable_n;
  end
  always @(posedge pins.chip_strobe_n) begin
    cycles++;
    last = wr_n ? (cmd_n ? cmpd : ctrl) : pins.io_bus_out;
    if (!wr_n) begin
      if (cmd_n) cmpd = pins.io_bus_out;
      else ctrl = pins.io_bus_out;
      hits = 0;
      foreach (KEYS[i]) hits += int'(KEYS[i] == cmpd);
      // Control bit 15 stands in for a register-set switch, which drops the match state
      if (!cmd_n && ctrl[15]) hits = 0;
      flags.own_hit_n = hits == 0;
      flags.own_multi_hit_n = hits < 2;
    end
    flags.cascade_match_out_n = chain_n ||
      (pins.cascade_match_in_n && (!ctrl[0] || hits == 0));
    flags.cascade_full_out_n = pins.cascade_full_in_n || (ctrl[1] && !ctrl[2]);
  end
endmodule : camhp_dev_model

/* test_cam_host_port_cascade_flags.sv */
`timescale 1ns/100ps
`define CHK(n, e, g) begin \
  total_checks++; \
  if ((g) !== (e)) begin \
    mismatches++; \
    $display("[ERR] %s exp %h got %h", n, e, g); \
  end \
end
module test_cam_host_port_cascade_flags;
  localparam logic [15:0] KEY [4] = '{16'h1234, 16'h00aa, 16'h5a5a, 16'hbeef};
  logic clock, rst_n, ch, sw;
  camhp_pkg::camhp_axi_req_type axi_req;
  camhp_pkg::camhp_axi_resp_type axi_resp;
  camhp_pkg::camhp_pins_type pins;
  camhp_pkg::camhp_flags_type flags;
  logic [15:0] io_bus_in, v, ctl, cmp;
  logic [31:0] rd, c;
  logic [1:0] rsp, t;
  int mismatches, total_checks, seed, n0;
  camhp_host #(.STROBE_LOW(2), .INIT_LEN(2)) u_camhp_host (.clock(clock), .rst_n(rst_n),
    .axi_req(axi_req), .axi_resp(axi_resp), .pins(pins), .io_bus_in(io_bus_in), .flags(flags));
  camhp_dev_model u_camhp_dev_model (.pins(pins), .io_bus_in(io_bus_in), .flags(flags));
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  task automatic end_sim;
    $display("Checks %0d, mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : end_sim
  task automatic guard(input int n);
    if (n > 80) begin
      mismatches++;
      $display("[ERR] wait_bound exp %0d got %0d", 80, n);
      end_sim();
    end
  endtask : guard
  // Leading edge keeps a release and the next request out of one time step
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge clock);
    axi_req.awaddr <= a;
    axi_req.wdata <= d;
    axi_req.wstrb <= 4'hf;
    axi_req.awvalid <= 1'b1;
    axi_req.wvalid <= 1'b1;
    axi_req.bready <= 1'b1;
    do begin
      @(posedge clock);
      n++;
      guard(n);
    end while (axi_resp.awready !== 1'b1 || axi_resp.wready !== 1'b1);
    axi_req.awvalid <= 1'b0;
    axi_req.wvalid <= 1'b0;
    while (axi_resp.bvalid !== 1'b1) begin
      @(posedge clock);
      n++;
      guard(n);
    end
    r = axi_resp.bresp;
    axi_req.bready <= 1'b0;
  endtask : axi_wr
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge clock);
    axi_req.araddr <= a;
    axi_req.arvalid <= 1'b1;
    axi_req.rready <= 1'b1;
    do begin
      @(posedge clock);
      n++;
      guard(n);
    end while (axi_resp.arready !== 1'b1);
    axi_req.arvalid <= 1'b0;
    while (axi_resp.rvalid !== 1'b1) begin
      @(posedge clock);
      n++;
      guard(n);
    end
    d = axi_resp.rdata;
    r = axi_resp.rresp;
    axi_req.rready <= 1'b0;
  endtask : axi_rd
  task automatic wait_done;
    int n;
    n = 0;
    do begin
      axi_rd(camhp_pkg::REG_STATUS, rd, rsp);
      n++;
      guard(n);
    end while (rd[camhp_pkg::ST_DONE] !== 1'b1);
  endtask : wait_done
  task automatic dev_cycle(input logic [31:0] o, input logic [15:0] d);
    axi_wr(camhp_pkg::REG_WDATA, {16'h0000, d}, rsp);
    axi_wr(camhp_pkg::REG_CTRL, o, rsp);
    wait_done();
  endtask : dev_cycle
  // Status bits 5..2: system full, system match, own multi-hit, own hit
  function automatic logic [3:0] exp_flags(input logic [15:0] k, m, input logic e);
    int h;
    h = (m == 16'h1234) ? 2 : (m == 16'h00aa || m == 16'h5a5a) ? 1 : 0;
    return {!(k[1] && !k[2]), e && k[0] && h > 0, h > 1, h > 0};
  endfunction : exp_flags
  always @(posedge clock) begin
    if (rst_n && pins.init_clear_n === 1'b0) begin
      `CHK("strobe_in_init", 1'b1, pins.chip_strobe_n)
      `CHK("chain_in_init", 1'b1, pins.chain_enable_n)
    end
    if (pins.chip_strobe_n === 1'b0) `CHK("bus_owner", pins.direction_sel_n, pins.io_bus_oe_n)
  end
  initial begin
    seed = 44;
    {mismatches, total_checks} = '0;
    {ctl, cmp} = 32'h0000_0000;
    sw = 1'b0;
    rst_n = 1'b0;
    axi_req = '0;
    repeat (4) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    `CHK("idle_pins", 6'h3f, {pins.chip_strobe_n, pins.init_clear_n, pins.chain_enable_n,
      pins.direction_sel_n, pins.command_or_data_n, pins.io_bus_oe_n})
    `CHK("chain_ties", 2'b10, {pins.cascade_match_in_n, pins.cascade_full_in_n})
    axi_wr(8'h10, 32'h0000_0001, rsp);
    `CHK("wr_unmapped", camhp_pkg::RESP_SLVERR, rsp)
    axi_rd(8'h10, rd, rsp);
    `CHK("rd_unmapped", {camhp_pkg::RESP_SLVERR, 32'h0000_0000}, {rsp, rd})
    $display("test reset_and_map done");
    dev_cycle(32'h0000_0010, 16'h0000);
    $display("test init done");
    for (int i = 0; i < 40; i++) begin
      t = (i < 4) ? 2'(i) : 2'($random(seed));
      ch = 1'($random(seed));
      v = t[1] ? KEY[2'($random(seed))] : 16'($random(seed));
      c = {28'h000_0000, ch, t, 1'b1};
      dev_cycle(c, v);
      // A control write with bit 15 acts as a set switch and drops the match state
      if (!t[0] && t[1]) {cmp, sw} = {v, 1'b0};
      if (!t[0] && !t[1]) {ctl, sw} = {v, v[15]};
      `CHK("captured", {t[0], t[1], ~ch}, {u_camhp_dev_model.wr_n, u_camhp_dev_model.cmd_n,
        u_camhp_dev_model.chain_n})
      `CHK("stored", {ctl, cmp}, {u_camhp_dev_model.ctrl, u_camhp_dev_model.cmpd})
      `CHK("flags", exp_flags(ctl, sw ? 16'h0000 : cmp, ch), rd[5:2])
      if (t[0]) begin
        axi_rd(camhp_pkg::REG_RDATA, rd, rsp);
        `CHK("rdata", t[1] ? cmp : ctl, rd[15:0])
      end
    end
    $display("test cycle_types_and_flags done");
    n0 = u_camhp_dev_model.cycles;
    axi_wr(camhp_pkg::REG_WDATA, 32'h0000_00aa, rsp);
    axi_wr(camhp_pkg::REG_CTRL, 32'h0000_0005, rsp);
    axi_wr(camhp_pkg::REG_CTRL, 32'h0000_0001, rsp);
    `CHK("busy_resp", camhp_pkg::RESP_OKAY, rsp)
    wait_done();
    cmp = 16'h00aa;
    `CHK("one_cycle", n0 + 1, u_camhp_dev_model.cycles)
    `CHK("busy_kept", {ctl, cmp}, {u_camhp_dev_model.ctrl, u_camhp_dev_model.cmpd})
    $display("test busy_refusal done");
    end_sim();
  end
endmodule : test_cam_host_port_cascade_flags
